// File: dv/cdfc_port_model.sv
// Serial-port partner: takes record words with random stalls.
// Assumes clk_sys; stall holds off pops from the clock edge after it rises, as ready is registered.
`timescale 1ns/100ps
module cdfc_port_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic stall,
  output logic      pcmTxReady
);
  // Random ready keeps the record head standing over several cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) pcmTxReady <= 1'b0;
    else pcmTxReady <= !stall && ($urandom % 3 != 0);
  end
endmodule : cdfc_port_model

// File: dv/tb_codec_digital_filter_chain.sv
// Bench for the filter chain: registers, both streams, FIFO back-pressure.
// Assumes the port model pops record words.
`timescale 1ns/100ps
module tb_codec_digital_filter_chain import cdfc_pkg::*; ;
  logic               clk_sys = 0, nrst = 0, regWr = 0, regRd = 0, stall = 0;
  logic               adcValid = 0, pcmRxValid = 0;
  logic               adcReady, pcmTxValid, pcmTxReady, pcmRxReady, dacValid;
  logic [CDFC_AW-1:0] regAddr = '0;
  logic [CDFC_DW-1:0] regWdata = '0, regRdata;
  cdfc_stereo_t       adcData = '0, pcmRxData = '0, pcmTxData, dacData, x, y;
  int                 err_total = 0, n_compared = 0, taken = 0, popped = 0;

  always #20 clk_sys = ~clk_sys;

  cdfc_filter_chain u_dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .adcValid(adcValid), .adcReady(adcReady),
    .adcData(adcData), .pcmTxValid(pcmTxValid), .pcmTxReady(pcmTxReady), .pcmTxData(pcmTxData),
    .pcmRxValid(pcmRxValid), .pcmRxReady(pcmRxReady), .pcmRxData(pcmRxData), .dacValid(dacValid),
    .dacData(dacData));
  cdfc_port_model u_port (.clk_sys(clk_sys), .nrst(nrst), .stall(stall), .pcmTxReady(pcmTxReady));

  // ---------------------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  // Strobe is dropped one edge later so back-to-back calls never collide
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk("rdata", 32'(regRdata), 32'(e));
    @(posedge clk_sys);
  endtask : rd

  task automatic rec(input cdfc_stereo_t s);
    int i;
    adcData <= s;
    adcValid <= 1'b1;
    @(posedge clk_sys);
    adcValid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (pcmTxValid === 1'b1 && pcmTxReady === 1'b1) break;
    end
    if (i == 60) begin
      err_total++;
      summarize();
    end
    y = pcmTxData;
    @(posedge clk_sys);
  endtask : rec

  task automatic play(input cdfc_stereo_t s, input cdfc_stereo_t e);
    pcmRxData <= s;
    pcmRxValid <= 1'b1;
    @(posedge clk_sys);
    pcmRxValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("dacValid", 32'(dacValid), 1);
    chk("dacData", dacData, e);
    @(posedge clk_sys);
  endtask : play

  // Multiples of 8 keep the scaled expectations exact
  function automatic cdfc_stereo_t rnd();
    return cdfc_stereo_t'($urandom & 32'hfff8fff8);
  endfunction : rnd

  function automatic cdfc_stereo_t sc(cdfc_stereo_t s, int k);
    return {s.ch[1] >>> k, s.ch[0] >>> k};
  endfunction : sc

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h128fd650));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(CDFC_A_CTRL, 16'h0000);
    rd(CDFC_A_COEF0, 16'h4000);
    rd(5'h1f, 16'h0000);
    x = rnd();
    play(x, x);
    rec(x);
    chk("recPass", y, x);
    for (int k = 0; k < 4; k++) begin
      wr(CDFC_A_CTRL, (k < 3) ? 16'(k + 1) : 16'h000c);
      x = rnd();
      repeat (300) rec(x);
      chk("hpOn", 32'(y.ch[k / 3] > -16'sh0040 && y.ch[k / 3] < 16'sh0040), 1);
      chk("hpOff", 32'(y.ch[1 - k / 3]), 32'(x.ch[1 - k / 3]));
    end
    wr(CDFC_A_CTRL, 16'h0000);
    wr(CDFC_A_COEF0 + CDFC_C_HPL, 16'h2000);
    wr(CDFC_A_CTRL, 16'h0010);
    x = rnd();
    rec(x);
    chk("progL", y, {x.ch[1], x.ch[0] >>> 1});
    wr(CDFC_A_CTRL, 16'h0000);
    wr(CDFC_A_COEF0 + CDFC_C_BQ1, 16'h2000);
    wr(CDFC_A_COEF0 + CDFC_C_BQ2, 16'h2000);
    wr(CDFC_A_COEF0 + CDFC_C_DE, 16'h2000);
    wr(CDFC_A_CTRL, 16'h0040);
    rec(x);
    chk("fxRec", y, sc(x, 2));
    play(x, x);
    wr(CDFC_A_CTRL, 16'h00c0);
    rec(x);
    chk("fxOther", y, x);
    play(x, sc(x, 2));
    wr(CDFC_A_CTRL, 16'h01c0);
    play(x, sc(x, 3));
    stall <= 1'b1;
    adcValid <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      taken += int'(adcReady);
      @(posedge clk_sys);
    end
    adcValid <= 1'b0;
    @(negedge clk_sys);
    chk("full", 32'(adcReady), 0);
    stall <= 1'b0;
    repeat (200) begin
      @(negedge clk_sys);
      popped += int'(pcmTxValid & pcmTxReady);
    end
    chk("drain", popped, taken);
    chk("empty", 32'(pcmTxValid), 0);
    @(posedge clk_sys);
    rd(CDFC_A_STATUS, 16'h0140);
    rd(CDFC_A_RECCNT, 16'(1204 + taken));
    rd(CDFC_A_PLAYCNT, 16'h0004);
    chk("rxReady", 32'(pcmRxReady), 1);
    summarize();
  end
endmodule : tb_codec_digital_filter_chain

// File: hw/cdfc_biquad.sv
// One biquad section, direct form I, one channel, Q2.14 coefficients.
// Assumes one input sample per sample period; result stands one cycle later.
`timescale 1ns/100ps
module cdfc_biquad import cdfc_pkg::*; (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic inValid,
  input  cdfc_smp_t inSample,
  input  cdfc_bq_t  coef,
  input  wire logic bypass,
  input  wire logic flush,
  output logic      outValid,
  output cdfc_smp_t outSample
);

  cdfc_smp_t                    x1Q;
  cdfc_smp_t                    x2Q;
  cdfc_smp_t                    y1Q;
  cdfc_smp_t                    y2Q;
  logic signed [CDFC_ACCW-1:0]  acc;
  logic signed [CDFC_ACCW-1:0]  shifted;
  cdfc_smp_t                    yD;

  always_comb begin
    acc = $signed(coef.b0) * inSample + $signed(coef.b1) * x1Q + $signed(coef.b2) * x2Q
        + $signed(coef.a1) * y1Q + $signed(coef.a2) * y2Q;
    shifted = acc >>> CDFC_QF;
    // Saturate rather than wrap: a wrap is a full-scale click
    if (shifted > CDFC_ACCW'(CDFC_SMAX)) yD = CDFC_SMAX;
    else if (shifted < CDFC_ACCW'(CDFC_SMIN)) yD = CDFC_SMIN;
    else yD = cdfc_smp_t'(shifted);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      outValid  <= 1'b0;
      outSample <= '0;
    end else begin
      outValid <= inValid;
      if (inValid) outSample <= bypass ? inSample : yD;
    end
  end

  // History is cleared while bypassed so a later enable starts from silence
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      x1Q <= '0;
      x2Q <= '0;
      y1Q <= '0;
      y2Q <= '0;
    end else if (flush || (inValid && bypass)) begin
      x1Q <= '0;
      x2Q <= '0;
      y1Q <= '0;
      y2Q <= '0;
    end else if (inValid) begin
      x1Q <= inSample;
      x2Q <= x1Q;
      y1Q <= yD;
      y2Q <= y1Q;
    end
  end

endmodule : cdfc_biquad

// File: hw/cdfc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes both sides run on clk_sys; depth is a power of two.
`timescale 1ns/100ps
module cdfc_fifo import cdfc_pkg::*; #(
  parameter int W = 32,
  parameter int D = CDFC_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData,
  output logic [$clog2(D):0] level
);

  localparam int PW = $clog2(D);

  logic [W-1:0]  memQ [D];
  logic [PW-1:0] wrPtrQ;
  logic [PW-1:0] rdPtrQ;
  logic [PW:0]   countQ;
  logic          push;
  logic          pop;

  assign inReady  = (countQ != PW'(0) + (PW+1)'(D));
  assign outValid = (countQ != '0);
  assign outData  = memQ[rdPtrQ];
  assign level    = countQ;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      memQ[wrPtrQ] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (push) wrPtrQ <= wrPtrQ + PW'(1);
      if (pop) rdPtrQ <= rdPtrQ + PW'(1);
      if (push && !pop) countQ <= countQ + (PW+1)'(1);
      else if (pop && !push) countQ <= countQ - (PW+1)'(1);
    end
  end

endmodule : cdfc_fifo

// File: hw/cdfc_filter_chain.sv
// Digital filter chain of a stereo codec: record and playback paths.
// Assumes converter and serial-port logic on clk_sys, one sample pair per
// sample period, and a register master that follows the plain strobe port.
//
// Notes on behaviour
// [RULE1] Each record channel's DC block has a fixed-corner mode and a host-coefficient mode.
// [RULE2] Fixed mode selects bypass or corner 0.0045, 0.0125 or 0.025 of sample rate.
// [RULE3] Left and right DC block selections are held and applied independently.
// [RULE4] Host loads custom DC block coefficients before setting the per-channel enables.
// [RULE5] Record path: converter, DC block, effects stage, then serial port out.
// [RULE6] Playback path: serial port in, effects stage, de-emphasis, then converter.
// [RULE7] Effects stage serves the record path or the playback path, never both.
// [RULE8] Effects stage is two biquad sections in cascade.
// [RULE9] Host disables effects before rewriting biquad coefficients, re-enables afterwards.
// [RULE10] De-emphasis response comes from host-programmable coefficients.
// [RULE11] The path not owning the effects stage passes its samples unchanged.
// [RULE12] Every enabled stage yields one output sample per input sample.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module cdfc_filter_chain import cdfc_pkg::*; (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic [CDFC_AW-1:0] regAddr,
  input  wire logic [CDFC_DW-1:0] regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic [CDFC_DW-1:0]      regRdata,
  input  wire logic               adcValid,
  output logic                    adcReady,
  input  cdfc_stereo_t            adcData,
  output logic                    pcmTxValid,
  input  wire logic               pcmTxReady,
  output cdfc_stereo_t            pcmTxData,
  input  wire logic               pcmRxValid,
  output logic                    pcmRxReady,
  input  cdfc_stereo_t            pcmRxData,
  output logic                    dacValid,
  output cdfc_stereo_t            dacData
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  cdfc_ctrl_t           ctrlQ;
  cdfc_coef_t           coefQ [CDFC_NCOEF];
  logic [CDFC_DW-1:0]   rdataQ;
  logic [CDFC_DW-1:0]   rdataD;
  logic [CDFC_DW-1:0]   recCntQ;
  logic [CDFC_DW-1:0]   playCntQ;
  logic [CDFC_AW-1:0]   coefIdx;
  logic                 coefHit;
  logic                 routeFlush;
  logic                 fxEnPrevQ;
  logic                 fxRoutePrevQ;

  cdfc_bq_t             hpCoef [2];
  logic [1:0]           hpBypass;
  cdfc_bq_t             bq1Coef;
  cdfc_bq_t             bq2Coef;
  cdfc_bq_t             deCoef;

  logic                 recTake;
  logic [1:0]           hpV;
  cdfc_stereo_t         hpOut;
  logic                 fxInV;
  cdfc_stereo_t         fxIn;
  logic [1:0]           fx1V;
  cdfc_stereo_t         fx1Out;
  logic [1:0]           fx2V;
  cdfc_stereo_t         fx2Out;
  logic                 recD1VQ;
  logic                 recD2VQ;
  cdfc_stereo_t         recD1Q;
  cdfc_stereo_t         recD2Q;
  logic                 playD1VQ;
  logic                 playD2VQ;
  cdfc_stereo_t         playD1Q;
  cdfc_stereo_t         playD2Q;
  logic                 fifoInV;
  cdfc_stereo_t         fifoInD;
  logic                 deInV;
  cdfc_stereo_t         deIn;
  logic [1:0]           deV;
  logic [CDFC_LVLW-1:0] fifoLevel;
  logic                 fxOnRec;
  logic                 fxOnPlay;

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  assign coefHit = (regAddr >= CDFC_A_COEF0) && (regAddr < CDFC_A_COEF_END);
  assign coefIdx = regAddr - CDFC_A_COEF0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrlQ <= CDFC_CTRL_RST;
    end else if (regWr && regAddr == CDFC_A_CTRL) begin
      ctrlQ <= cdfc_ctrl_t'(regWdata[$bits(cdfc_ctrl_t)-1:0]);
    end
  end

  // Coefficients reset to a pass-through response so any enable is harmless
  generate
    for (genvar i = 0; i < CDFC_NCOEF; i++) begin : g_coef
      localparam cdfc_coef_t RST = (i == CDFC_C_HPL || i == CDFC_C_HPR || i == CDFC_C_BQ1
                                    || i == CDFC_C_BQ2 || i == CDFC_C_DE) ? CDFC_UNITY : CDFC_ZERO;
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          coefQ[i] <= RST;
        end else if (regWr && coefHit && coefIdx == CDFC_AW'(i)) begin
          coefQ[i] <= cdfc_coef_t'(regWdata);
        end
      end
    end
  endgenerate

  always_comb begin
    rdataD = '0;
    if (regAddr == CDFC_A_CTRL) rdataD = CDFC_DW'(ctrlQ);
    else if (regAddr == CDFC_A_STATUS) rdataD = CDFC_DW'({fxOnPlay, fxOnRec, adcReady, fifoLevel});
    else if (coefHit) rdataD = coefQ[coefIdx];
    else if (regAddr == CDFC_A_RECCNT) rdataD = recCntQ;
    else if (regAddr == CDFC_A_PLAYCNT) rdataD = playCntQ;
  end

  // Read data stand only in the cycle after the strobe; otherwise zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) rdataQ <= '0;
    else rdataQ <= regRd ? rdataD : '0;
  end
  assign regRdata = rdataQ;

  // ---------------------------------------------------------------------------
  // Coefficient selection
  // ---------------------------------------------------------------------------
  always_comb begin
    hpCoef[0] = ctrlQ.progL
              ? '{coefQ[CDFC_C_HPL], coefQ[CDFC_C_HPL+1], CDFC_ZERO, coefQ[CDFC_C_HPL+2], CDFC_ZERO}
              : cdfc_hp_std(ctrlQ.hpSelL); // RULE1 RULE2
    hpCoef[1] = ctrlQ.progR
              ? '{coefQ[CDFC_C_HPR], coefQ[CDFC_C_HPR+1], CDFC_ZERO, coefQ[CDFC_C_HPR+2], CDFC_ZERO}
              : cdfc_hp_std(ctrlQ.hpSelR); // RULE1 RULE3
    hpBypass[0] = !ctrlQ.progL && ctrlQ.hpSelL == CDFC_HP_OFF; // RULE2
    hpBypass[1] = !ctrlQ.progR && ctrlQ.hpSelR == CDFC_HP_OFF; // RULE3
  end

  assign bq1Coef = '{coefQ[CDFC_C_BQ1], coefQ[CDFC_C_BQ1+1], coefQ[CDFC_C_BQ1+2],
                     coefQ[CDFC_C_BQ1+3], coefQ[CDFC_C_BQ1+4]};
  assign bq2Coef = '{coefQ[CDFC_C_BQ2], coefQ[CDFC_C_BQ2+1], coefQ[CDFC_C_BQ2+2],
                     coefQ[CDFC_C_BQ2+3], coefQ[CDFC_C_BQ2+4]};
  assign deCoef  = '{coefQ[CDFC_C_DE], coefQ[CDFC_C_DE+1], CDFC_ZERO,
                     coefQ[CDFC_C_DE+2], CDFC_ZERO}; // RULE10

  // ---------------------------------------------------------------------------
  // Effects ownership
  // ---------------------------------------------------------------------------
  assign fxOnRec  = ctrlQ.fxEn && !ctrlQ.fxRouteDac; // RULE7
  assign fxOnPlay = ctrlQ.fxEn && ctrlQ.fxRouteDac;  // RULE7

  // A change of owner or enable would otherwise leak one path's history into
  // the other; flushing costs a short transient but never a loud one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fxEnPrevQ    <= 1'b0;
      fxRoutePrevQ <= 1'b0;
    end else begin
      fxEnPrevQ    <= ctrlQ.fxEn;
      fxRoutePrevQ <= ctrlQ.fxRouteDac;
    end
  end
  assign routeFlush = (fxEnPrevQ != ctrlQ.fxEn) || (fxRoutePrevQ != ctrlQ.fxRouteDac);

  // ---------------------------------------------------------------------------
  // Datapath: per-channel sections
  // ---------------------------------------------------------------------------
  // The converter cannot be stalled inside the chain, so room for every
  // sample still in flight and for the one now offered is reserved first
  assign adcReady   = fifoLevel < CDFC_LVLW'(CDFC_DEPTH - CDFC_INFLIGHT);
  assign recTake    = adcValid && adcReady;
  assign pcmRxReady = 1'b1;

  assign fxInV = ctrlQ.fxRouteDac ? pcmRxValid : hpV[0]; // RULE7
  assign fxIn  = ctrlQ.fxRouteDac ? pcmRxData : hpOut;   // RULE5 RULE6

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      cdfc_biquad u_dc_block_stage (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .inValid   (recTake),
        .inSample  (adcData.ch[c]),
        .coef      (hpCoef[c]),
        .bypass    (hpBypass[c]),
        .flush     (1'b0),
        .outValid  (hpV[c]),
        .outSample (hpOut.ch[c])
      ); // RULE5 RULE12
      cdfc_biquad u_fx1 (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .inValid   (fxInV),
        .inSample  (fxIn.ch[c]),
        .coef      (bq1Coef),
        .bypass    (!ctrlQ.fxEn),
        .flush     (routeFlush),
        .outValid  (fx1V[c]),
        .outSample (fx1Out.ch[c])
      ); // RULE8
      cdfc_biquad u_fx2 (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .inValid   (fx1V[c]),
        .inSample  (fx1Out.ch[c]),
        .coef      (bq2Coef),
        .bypass    (!ctrlQ.fxEn),
        .flush     (routeFlush),
        .outValid  (fx2V[c]),
        .outSample (fx2Out.ch[c])
      ); // RULE8
      cdfc_biquad u_deemph (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .inValid   (deInV),
        .inSample  (deIn.ch[c]),
        .coef      (deCoef),
        .bypass    (!ctrlQ.deEn),
        .flush     (1'b0),
        .outValid  (deV[c]),
        .outSample (dacData.ch[c])
      ); // RULE6 RULE10
    end
  endgenerate

  assign dacValid = deV[0];

  // ---------------------------------------------------------------------------
  // Bypass delay lines for the path that does not own the effects stage
  // ---------------------------------------------------------------------------
  // Both routes give equal latency, so switching owner does not reorder samples
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      recD1VQ <= 1'b0;
      recD2VQ <= 1'b0;
      recD1Q  <= '0;
      recD2Q  <= '0;
    end else begin
      recD1VQ <= hpV[0];
      recD2VQ <= recD1VQ;
      recD1Q  <= hpOut;
      recD2Q  <= recD1Q;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      playD1VQ <= 1'b0;
      playD2VQ <= 1'b0;
      playD1Q  <= '0;
      playD2Q  <= '0;
    end else begin
      playD1VQ <= pcmRxValid;
      playD2VQ <= playD1VQ;
      playD1Q  <= pcmRxData;
      playD2Q  <= playD1Q;
    end
  end

  assign fifoInV = ctrlQ.fxRouteDac ? recD2VQ : fx2V[0]; // RULE11
  assign fifoInD = ctrlQ.fxRouteDac ? recD2Q : fx2Out;   // RULE11
  assign deInV   = ctrlQ.fxRouteDac ? fx2V[0] : playD2VQ; // RULE11
  assign deIn    = ctrlQ.fxRouteDac ? fx2Out : playD2Q;   // RULE6

  // ---------------------------------------------------------------------------
  // Record output buffer
  // ---------------------------------------------------------------------------
  cdfc_fifo #(
    .W (2 * CDFC_SW),
    .D (CDFC_DEPTH)
  ) u_rec_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .inValid  (fifoInV),
    .inReady  (),
    .inData   (fifoInD),
    .outValid (pcmTxValid),
    .outReady (pcmTxReady),
    .outData  (pcmTxData),
    .level    (fifoLevel)
  ); // RULE5

  // ---------------------------------------------------------------------------
  // Sample counters
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      recCntQ  <= '0;
      playCntQ <= '0;
    end else begin
      if (fifoInV) recCntQ <= recCntQ + CDFC_DW'(1);    // RULE12
      if (dacValid) playCntQ <= playCntQ + CDFC_DW'(1); // RULE12
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_rec_take;
    recTake;
  endsequence
  sequence s_play_take;
    pcmRxValid;
  endsequence
  sequence s_rec_bypassed;
    hpV[0] && ctrlQ.fxRouteDac ##1 ctrlQ.fxRouteDac ##1 ctrlQ.fxRouteDac;
  endsequence

  a_rec_latency: assert property (s_rec_take |-> ##3 fifoInV) // RULE5 RULE12
    else $error("record sample did not reach the buffer after three cycles");
  a_play_latency: assert property (s_play_take |-> ##3 dacValid) // RULE6 RULE12
    else $error("playback sample did not reach the converter after three cycles");
  a_hp_left_pass: assert property ((recTake && ctrlQ.hpSelL == CDFC_HP_OFF && !ctrlQ.progL) // RULE3
    |=> hpOut.ch[0] == $past(adcData.ch[0]))
    else $error("bypassed left DC block altered the sample");
  a_hp_std_coef: assert property ((!ctrlQ.progR && ctrlQ.hpSelR == CDFC_HP_C0125) // RULE2
    |-> hpCoef[1].b0 == CDFC_G0125 && hpCoef[1].a1 == CDFC_P0125)
    else $error("right DC block fixed corner coefficients wrong");
  a_hp_prog_coef: assert property (ctrlQ.progL // RULE1
    |-> hpCoef[0].b0 == coefQ[CDFC_C_HPL] && hpCoef[0].a1 == coefQ[CDFC_C_HPL+2] && !hpBypass[0])
    else $error("left DC block ignores host coefficients");
  a_fx_other_pass: assert property (s_rec_bypassed |-> fifoInV && fifoInD == $past(hpOut, 2)) // RULE11
    else $error("record path altered while effects serve playback");
  a_fx_cascade: assert property (fx1V[0] |=> fx2V[0] && fx2V[1]) // RULE8
    else $error("second biquad did not follow the first");
  a_fx_owner: assert property (fx1V[0] |-> ($past(ctrlQ.fxRouteDac) ? $past(pcmRxValid) : $past(hpV[0]))) // RULE7
    else $error("effects stage fed by the path it does not serve");
  a_de_coef: assert property ((ctrlQ.deEn && deInV) // RULE10
    |-> deCoef.b0 == coefQ[CDFC_C_DE] && deCoef.a1 == coefQ[CDFC_C_DE+2])
    else $error("de-emphasis not using host coefficients");

endmodule : cdfc_filter_chain

// File: shared/cdfc_pkg.sv
// Shared constants and types for the codec digital filter chain.
// Assumes a single clk_sys domain and 16-bit two's-complement audio samples.
package cdfc_pkg;

  // ---------------------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------------------
  localparam int CDFC_AW       = 5;
  localparam int CDFC_DW       = 16;
  localparam int CDFC_SW       = 16;
  localparam int CDFC_QF       = 14;
  localparam int CDFC_ACCW     = 36;
  localparam int CDFC_DEPTH    = 32;
  localparam int CDFC_LVLW     = 6;
  localparam int CDFC_NCOEF    = 19;
  localparam int CDFC_INFLIGHT = 3;

  // ---------------------------------------------------------------------------
  // Register map (word index on the register port)
  // ---------------------------------------------------------------------------
  localparam logic [CDFC_AW-1:0] CDFC_A_CTRL     = 5'h00;
  localparam logic [CDFC_AW-1:0] CDFC_A_STATUS   = 5'h01;
  localparam logic [CDFC_AW-1:0] CDFC_A_COEF0    = 5'h02;
  localparam logic [CDFC_AW-1:0] CDFC_A_COEF_END = 5'h15;
  localparam logic [CDFC_AW-1:0] CDFC_A_RECCNT   = 5'h15;
  localparam logic [CDFC_AW-1:0] CDFC_A_PLAYCNT  = 5'h16;

  // Coefficient slots, relative to CDFC_A_COEF0
  localparam logic [CDFC_AW-1:0] CDFC_C_HPL = 5'h00;
  localparam logic [CDFC_AW-1:0] CDFC_C_HPR = 5'h03;
  localparam logic [CDFC_AW-1:0] CDFC_C_BQ1 = 5'h06;
  localparam logic [CDFC_AW-1:0] CDFC_C_BQ2 = 5'h0b;
  localparam logic [CDFC_AW-1:0] CDFC_C_DE  = 5'h10;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef logic signed [CDFC_SW-1:0] cdfc_smp_t;
  typedef logic signed [CDFC_DW-1:0] cdfc_coef_t;

  typedef struct packed {
    cdfc_smp_t [1:0] ch;
  } cdfc_stereo_t;

  typedef struct packed {
    cdfc_coef_t b0;
    cdfc_coef_t b1;
    cdfc_coef_t b2;
    cdfc_coef_t a1;
    cdfc_coef_t a2;
  } cdfc_bq_t;

  typedef enum logic [1:0] {
    CDFC_HP_OFF   = 2'b00,
    CDFC_HP_C0045 = 2'b01,
    CDFC_HP_C0125 = 2'b10,
    CDFC_HP_C025  = 2'b11
  } cdfc_hpsel_t;

  typedef struct packed {
    logic        deEn;
    logic        fxRouteDac;
    logic        fxEn;
    logic        progR;
    logic        progL;
    cdfc_hpsel_t hpSelR;
    cdfc_hpsel_t hpSelL;
  } cdfc_ctrl_t;

  localparam cdfc_ctrl_t CDFC_CTRL_RST = 9'h000;

  // ---------------------------------------------------------------------------
  // Coefficients, Q2.14
  // ---------------------------------------------------------------------------
  localparam cdfc_coef_t CDFC_UNITY   = 16'sh4000;
  localparam cdfc_coef_t CDFC_ZERO    = 16'sh0000;
  localparam cdfc_coef_t CDFC_G0045   = 16'sh3f1b;
  localparam cdfc_coef_t CDFC_P0045   = 16'sh3e37;
  localparam cdfc_coef_t CDFC_G0125   = 16'sh3d95;
  localparam cdfc_coef_t CDFC_P0125   = 16'sh3b2b;
  localparam cdfc_coef_t CDFC_G025    = 16'sh3b59;
  localparam cdfc_coef_t CDFC_P025    = 16'sh36b2;
  localparam cdfc_smp_t  CDFC_SMAX    = 16'sh7fff;
  localparam cdfc_smp_t  CDFC_SMIN    = -16'sh7fff - 16'sh0001;

  // First-order high-pass y = g*(x - x1) + p*y1 for the fixed corners
  function automatic cdfc_bq_t cdfc_hp_std(input cdfc_hpsel_t sel);
    cdfc_coef_t g;
    cdfc_coef_t p;
    g = CDFC_UNITY;
    p = CDFC_ZERO;
    unique case (sel)
      CDFC_HP_OFF:   begin g = CDFC_UNITY; p = CDFC_ZERO; end
      CDFC_HP_C0045: begin g = CDFC_G0045; p = CDFC_P0045; end
      CDFC_HP_C0125: begin g = CDFC_G0125; p = CDFC_P0125; end
      CDFC_HP_C025:  begin g = CDFC_G025;  p = CDFC_P025;  end
    endcase
    return '{b0: g, b1: -g, b2: CDFC_ZERO, a1: p, a2: CDFC_ZERO};
  endfunction : cdfc_hp_std

endpackage : cdfc_pkg
